/* core/uiq_flags.sv */
// Purpose: usb bus and endpoint event flags, enables and shared interrupt request
// Assumes: sie inputs share clk; usb_dp/usb_dm come from pins
// Notes:   flags clear by writing zero; a set in the same cycle wins
`timescale 1ns/100ps
`default_nettype none
module uiq_flags #(
    parameter int SUSP_CYCLES   = uiq_pkg::SUSP_CYC,
    parameter int RST_CYCLES    = uiq_pkg::BUS_RST_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       usb_dp,
    input  wire logic                       usb_dm,
    input  wire uiq_pkg::uiq_sie_t          sie,
    input  wire logic [uiq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [uiq_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            irq,
    output logic                            sie_clk_en,
    output logic                            nak_reply,
    output logic [2:0]                      nak_reply_ep
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0]                 line_s1;
        logic [1:0]                 line_s2;
        logic [1:0]                 line_prev;
        logic [uiq_pkg::CNT_W-1:0]  idle_cnt;
        logic [uiq_pkg::CNT_W-1:0]  se0_cnt;
        logic [3:0]                 glb;
        logic [4:0]                 tx_drain_summary;
        logic [4:0]                 rx_fill_summary;
        logic [4:0]                 busy_reply_summary;
        logic [3:0]                 glb_en;
        logic [4:0]                 in_en;
        logic [4:0]                 out_en;
        logic [4:0]                 nak_en;
        logic [4:0]                 in_full_prev;
        logic [4:0]                 out_full_prev;
        logic                       nak;
        logic [2:0]                 nak_ep;
        logic                       irq;
        logic                       clk_en;
        logic                       awv;
        logic [7:0]                 aw_idx;
        logic                       aw_ok;
        logic                       wv;
        logic [7:0]                 wdata;
        logic                       wstrb0;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [7:0]                 rdata;
        logic [1:0]                 rresp;
    } uiq_state_t;

    uiq_state_t q;
    uiq_state_t d;

    localparam logic [uiq_pkg::CNT_W-1:0] SUSP_LAST = uiq_pkg::CNT_W'(SUSP_CYCLES - 1);
    localparam logic [uiq_pkg::CNT_W-1:0] RST_LAST  = uiq_pkg::CNT_W'(RST_CYCLES - 1);
    // lines idle at j, so the synchronisers reset there and no false packet end follows reset
    localparam logic [1:0]                LINE_J    = 2'h2;
    localparam logic [1:0]                LINE_SE0  = 2'h0;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // odd endpoint of a pair carries the flags, the even partner is held quiet
    function automatic logic [4:0] pair_mask(input logic [1:0] p);
        pair_mask = {p[1], 1'b0, p[0], 2'b00};
    endfunction : pair_mask

    function automatic logic map_ok(input logic [uiq_pkg::ADDR_W-1:0] a);
        map_ok = (a[1:0] == 2'h0) && (a[9:2] >= uiq_pkg::IDX_GLB_EN)
                 && (a[9:2] <= uiq_pkg::IDX_NAK_FLAGS);
    endfunction : map_ok

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic       se0;
    logic       line_j;
    logic       act;
    logic       wr_go;
    logic [7:0] wclr;
    logic [4:0] set_in;
    logic [4:0] set_out;
    logic [4:0] set_nak;
    logic [3:0] set_glb;

    always_comb begin
        d           = q;
        d.line_s1   = {usb_dp, usb_dm};
        d.line_s2   = q.line_s1;
        d.line_prev = q.line_s2;
        se0         = (q.line_s2 == LINE_SE0);
        line_j      = (q.line_s2 == LINE_J);
        // se0 and any line change count as activity, a steady idle line does not
        act         = se0 || (q.line_s2 != q.line_prev);
        set_glb     = 4'h0;
        // bus reset: only a flag, nothing else is reset here
        d.se0_cnt   = se0 ? ((q.se0_cnt == RST_LAST) ? q.se0_cnt : q.se0_cnt + 1'b1) : '0;
        if (se0 && (q.se0_cnt == RST_LAST - 1'b1)) begin
            set_glb[uiq_pkg::BIT_RST] = 1'b1;
        end
        if (line_j && (q.line_prev == LINE_SE0) && (q.se0_cnt < RST_LAST)) begin
            set_glb[uiq_pkg::BIT_EOP] = 1'b1;
        end
        if (act && q.glb[uiq_pkg::BIT_SUSP]) begin
            set_glb[uiq_pkg::BIT_WAKE] = 1'b1;
        end
        if (act || q.glb[uiq_pkg::BIT_SUSP]) begin
            d.idle_cnt = '0;
        end else if (q.idle_cnt == SUSP_LAST) begin
            set_glb[uiq_pkg::BIT_SUSP] = 1'b1;
            d.idle_cnt = '0;
        end else begin
            d.idle_cnt = q.idle_cnt + 1'b1;
        end
        // fifo edges, quiet partner of a pair never flags
        d.in_full_prev  = sie.in_full;
        d.out_full_prev = sie.out_full;
        set_in  = q.in_full_prev & ~sie.in_full & ~pair_mask(sie.pair_in);
        set_out = ~q.out_full_prev & sie.out_full & ~pair_mask(sie.pair_out);
        set_nak = 5'h00;
        d.nak   = 1'b0;
        d.nak_ep = q.nak_ep;
        if (sie.in_token && (sie.in_token_ep < 3'(uiq_pkg::EP_N))
            && !sie.in_ready[sie.in_token_ep]) begin
            d.nak    = 1'b1;
            d.nak_ep = sie.in_token_ep;
            set_nak[sie.in_token_ep] = 1'b1;
        end
        set_nak = set_nak & ~pair_mask(sie.pair_in);
        // write channel: address and data taken in either order
        if (s_axi_awvalid && q.awready) begin
            d.awv    = 1'b1;
            d.aw_idx = s_axi_awaddr[9:2];
            d.aw_ok  = map_ok(s_axi_awaddr);
        end
        if (s_axi_wvalid && q.wready) begin
            d.wv     = 1'b1;
            d.wdata  = s_axi_wdata[7:0];
            d.wstrb0 = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        wr_go = q.awv && q.wv && !q.bvalid && q.wstrb0 && q.aw_ok;
        wclr  = 8'h00;
        if (q.awv && q.wv && !q.bvalid) begin
            d.awv    = 1'b0;
            d.wv     = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = q.aw_ok ? uiq_pkg::RESP_OKAY : uiq_pkg::RESP_SLVERR;
        end
        if (wr_go) begin
            wclr = ~q.wdata;
            case (q.aw_idx)
                uiq_pkg::IDX_GLB_EN: d.glb_en = q.wdata[3:0];
                uiq_pkg::IDX_IN_EN:  d.in_en  = q.wdata[4:0];
                uiq_pkg::IDX_OUT_EN: d.out_en = q.wdata[4:0];
                uiq_pkg::IDX_NAK_EN: d.nak_en = q.wdata[4:0];
                default: ;
            endcase
        end
        // writing zero clears, a set arriving in the same cycle wins
        d.glb  = (q.glb & ~((q.aw_idx == uiq_pkg::IDX_GLB_FLAGS) ? wclr[3:0] : 4'h0))
                 | set_glb;
        d.tx_drain_summary  = (q.tx_drain_summary & ~((q.aw_idx == uiq_pkg::IDX_IN_FLAGS) ? wclr[4:0] : 5'h00))
                 | set_in;
        d.rx_fill_summary = (q.rx_fill_summary & ~((q.aw_idx == uiq_pkg::IDX_OUT_FLAGS) ? wclr[4:0] : 5'h00))
                 | set_out;
        d.busy_reply_summary = (q.busy_reply_summary & ~((q.aw_idx == uiq_pkg::IDX_NAK_FLAGS) ? wclr[4:0] : 5'h00))
                 | set_nak;
        d.clk_en = !d.glb[uiq_pkg::BIT_SUSP];
        d.irq = |(d.glb & d.glb_en) || |(d.tx_drain_summary & d.in_en) || |(d.rx_fill_summary & d.out_en)
                || |(d.busy_reply_summary & d.nak_en);
        d.awready = !d.awv;
        d.wready  = !d.wv;
        // read channel: one outstanding read, answered the cycle after acceptance
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp  = map_ok(s_axi_araddr) ? uiq_pkg::RESP_OKAY : uiq_pkg::RESP_SLVERR;
            case (map_ok(s_axi_araddr) ? s_axi_araddr[9:2] : 8'h00)
                uiq_pkg::IDX_GLB_EN:    d.rdata = {4'h0, q.glb_en};
                uiq_pkg::IDX_IN_EN:     d.rdata = {3'h0, q.in_en};
                uiq_pkg::IDX_OUT_EN:    d.rdata = {3'h0, q.out_en};
                uiq_pkg::IDX_NAK_EN:    d.rdata = {3'h0, q.nak_en};
                uiq_pkg::IDX_GLB_FLAGS: d.rdata = {|q.glb, |q.tx_drain_summary, |q.rx_fill_summary, |q.busy_reply_summary,
                                                   q.glb};
                uiq_pkg::IDX_IN_FLAGS:  d.rdata = {3'h0, q.tx_drain_summary};
                uiq_pkg::IDX_OUT_FLAGS: d.rdata = {3'h0, q.rx_fill_summary};
                uiq_pkg::IDX_NAK_FLAGS: d.rdata = {3'h0, q.busy_reply_summary};
                default:                d.rdata = 8'h00;
            endcase
        end
        d.arready = !d.rvalid;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q         <= '0;
            q.line_s1   <= LINE_J;
            q.line_s2   <= LINE_J;
            q.line_prev <= LINE_J;
            q.glb     <= uiq_pkg::GLB_RST_VAL;
            q.nak_en  <= uiq_pkg::EP_RST_VAL;
            q.clk_en  <= 1'b1;
            q.awready <= 1'b1;
            q.wready  <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rdata   = {24'h000000, q.rdata};
    assign irq           = q.irq;
    assign sie_clk_en    = q.clk_en;
    assign nak_reply     = q.nak;
    assign nak_reply_ep  = q.nak_ep;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_nak_answer;
        @(posedge clk) disable iff (rst)
        (sie.in_token && sie.in_token_ep == 3'h0 && !sie.in_ready[0])
        |=> (nak_reply && nak_reply_ep == 3'h0);
    endproperty
    a_nak_answer: assert property (p_nak_answer) else $error("nak not sent");

    property p_nak_en_write;
        @(posedge clk) disable iff (rst)
        (wr_go && q.aw_idx == uiq_pkg::IDX_NAK_EN) |=> (q.nak_en == $past(q.wdata[4:0]));
    endproperty
    a_nak_en_write: assert property (p_nak_en_write) else $error("nak enable lost");

    property p_sum_bus;
        @(posedge clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready && map_ok(s_axi_araddr)
         && s_axi_araddr[9:2] == uiq_pkg::IDX_GLB_FLAGS)
        |=> (s_axi_rdata[7] == $past(|q.glb)) && (s_axi_rdata[6] == $past(|q.tx_drain_summary));
    endproperty
    a_sum_bus: assert property (p_sum_bus) else $error("bus summary wrong");

    property p_sum_fifo;
        @(posedge clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == uiq_pkg::IDX_GLB_FLAGS
         && map_ok(s_axi_araddr))
        |=> (s_axi_rdata[5] == $past(|q.rx_fill_summary)) && (s_axi_rdata[4] == $past(|q.busy_reply_summary));
    endproperty
    a_sum_fifo: assert property (p_sum_fifo) else $error("fifo summary wrong");

    property p_suspend;
        @(posedge clk) disable iff (rst)
        (!act && !q.glb[uiq_pkg::BIT_SUSP] && q.idle_cnt == SUSP_LAST)
        |=> (q.glb[uiq_pkg::BIT_SUSP] && !sie_clk_en);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend missed");

    property p_clk_back;
        @(posedge clk) disable iff (rst)
        $fell(q.glb[uiq_pkg::BIT_SUSP]) |-> sie_clk_en;
    endproperty
    a_clk_back: assert property (p_clk_back) else $error("clock not restarted");

    property p_wake;
        @(posedge clk) disable iff (rst)
        (act && q.glb[uiq_pkg::BIT_SUSP]) |=> q.glb[uiq_pkg::BIT_WAKE];
    endproperty
    a_wake: assert property (p_wake) else $error("wake missed");

    property p_in_drain;
        @(posedge clk) disable iff (rst)
        (q.in_full_prev[1] && !sie.in_full[1]) |=> q.tx_drain_summary[1] ##1
        (q.tx_drain_summary[1] || $past(wr_go && q.aw_idx == uiq_pkg::IDX_IN_FLAGS && !q.wdata[1]));
    endproperty
    a_in_drain: assert property (p_in_drain) else $error("in flag not held");

    property p_quiet_pair;
        @(posedge clk) disable iff (rst)
        (sie.pair_out[0] && !q.rx_fill_summary[2]) |=> !q.rx_fill_summary[2];
    endproperty
    a_quiet_pair: assert property (p_quiet_pair) else $error("even partner flagged");

    property p_irq;
        @(posedge clk) disable iff (rst)
        irq |-> (|(q.glb & q.glb_en) || |(q.tx_drain_summary & q.in_en) || |(q.rx_fill_summary & q.out_en)
                 || |(q.busy_reply_summary & q.nak_en));
    endproperty
    a_irq: assert property (p_irq) else $error("stray request");
endmodule : uiq_flags
`default_nettype wire

/* core/uiq_pkg.sv */
// Purpose: shared constants and carriers of the usb interrupt flag block
// Assumes: 10 MHz core clock, registers reached over axi4-lite
// Notes:   printed offsets are register indices, byte address is four times the index
package uiq_pkg;
    // ----------------------------------------
    // register indices and bus
    // ----------------------------------------
    localparam int          ADDR_W          = 10;
    localparam logic [7:0]  IDX_GLB_EN      = 8'he4;
    localparam logic [7:0]  IDX_IN_EN       = 8'he5;
    localparam logic [7:0]  IDX_OUT_EN      = 8'he6;
    localparam logic [7:0]  IDX_NAK_EN      = 8'he7;
    localparam logic [7:0]  IDX_GLB_FLAGS   = 8'he8;
    localparam logic [7:0]  IDX_IN_FLAGS    = 8'he9;
    localparam logic [7:0]  IDX_OUT_FLAGS   = 8'hea;
    localparam logic [7:0]  IDX_NAK_FLAGS   = 8'heb;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int          EP_N            = 5;
    localparam int          BIT_RST         = 3;
    localparam int          BIT_SUSP        = 2;
    localparam int          BIT_EOP         = 1;
    localparam int          BIT_WAKE        = 0;
    localparam logic [3:0]  GLB_RST_VAL     = 4'h0;
    localparam logic [4:0]  EP_RST_VAL      = 5'h00;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          SUSP_IDLE_MS    = 3;
    localparam int          BUS_RST_MS      = 10;
    localparam int          SUSP_CYC        = CLK_HZ / 1000 * SUSP_IDLE_MS;
    localparam int          BUS_RST_CYC     = CLK_HZ / 1000 * BUS_RST_MS;
    localparam int          CNT_W           = 17;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] in_full;
        logic [4:0] out_full;
        logic [4:0] in_ready;
        logic       in_token;
        logic [2:0] in_token_ep;
        logic [1:0] pair_in;
        logic [1:0] pair_out;
    } uiq_sie_t;
endpackage : uiq_pkg

/* testbench/testbench.sv */
// Purpose: self-checking bench of the usb interrupt flag block
// Assumes: short idle and reset counts set at the instance
// Notes:   idle bus suspends often, so reads mask the bits they ignore
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic              clk, rst, usb_dp, usb_dm, irq, sie_clk_en, nak_reply;
    uiq_pkg::uiq_sie_t sie;
    logic [9:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    logic [2:0]        nak_reply_ep, e;
    typedef struct packed {logic [7:0] v; logic [7:0] k; logic [1:0] r;} uiq_note_t;
    uiq_note_t         n, rq[$];
    logic [1:0]        bq[$];
    logic [2:0]        nq[$];
    logic [4:0]        m, q, r;
    int                fail_count = 0;
    int                checked = 0;

    uiq_flags #(.SUSP_CYCLES(20), .RST_CYCLES(40)) dut_u (
        .clk, .rst, .usb_dp, .usb_dm, .sie, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .sie_clk_en,
        .nak_reply, .nak_reply_ep);
    uiq_host_model host_u (.clk, .usb_dp, .usb_dm);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic cmp(input string what, input logic [31:0] x, input logic [31:0] got);
        checked++;
        if (got !== x) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, x, got);
        end
    endtask : cmp
    task automatic conclude();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    always @(negedge clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            n = rq.pop_front();
            cmp("rdata", {24'h0, n.v & n.k}, s_axi_rdata & {24'hffffff, n.k});
            cmp("rresp", {30'h0, n.r}, {30'h0, s_axi_rresp});
        end
        if (s_axi_bvalid && s_axi_bready) begin
            cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
        end
        if (nak_reply) begin
            e = (nq.size() != 0) ? nq.pop_front() : 3'bx;
            cmp("nak_reply_ep", {29'h0, e}, {29'h0, nak_reply_ep});
        end
    end
    // ----------------------------------------
    // bus master, valid held until taken
    // ----------------------------------------
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] rs = uiq_pkg::RESP_OKAY);
        logic ta, tw, tb;
        bq.push_back(rs);
        @(posedge clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) break;
        end
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] v, input logic [7:0] k = 8'hff,
                      input logic [1:0] rs = uiq_pkg::RESP_OKAY);
        logic ta, tr;
        rq.push_back('{v, k, rs});
        @(posedge clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) break;
        end
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic fifo_edges(input logic [4:0] mk);
        @(posedge clk);
        sie.in_full <= mk;
        sie.out_full <= 5'h00;
        repeat (2) @(posedge clk);
        sie.in_full <= 5'h00;
        sie.out_full <= mk;
        repeat (3) @(posedge clk);
    endtask : fifo_edges
    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp("irq", {31'h0, v}, {31'h0, irq});
    endtask : irq_is
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(56));
        rst = 1'b1;
        sie = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 'he4; i <= 'heb; i++) rd(i[7:0], 8'h00, (i == 'he8) ? 8'h7b : 8'hff);
        rd(8'h00, 8'h00, 8'hff, uiq_pkg::RESP_SLVERR);
        wr(8'h00, 8'h00, uiq_pkg::RESP_SLVERR);
        q = 5'($urandom_range(1, 31));
        wr(uiq_pkg::IDX_NAK_EN, {3'h7, q});
        rd(uiq_pkg::IDX_NAK_EN, {3'h0, q});
        m = 5'($urandom_range(1, 31));
        fifo_edges(m);
        rd(uiq_pkg::IDX_IN_FLAGS, {3'h0, m});
        rd(uiq_pkg::IDX_OUT_FLAGS, {3'h0, m});
        rd(uiq_pkg::IDX_GLB_FLAGS, 8'h60, 8'h60);
        wr(uiq_pkg::IDX_IN_EN, {3'h0, m});
        irq_is(1'b1);
        wr(uiq_pkg::IDX_IN_FLAGS, 8'hfe);
        rd(uiq_pkg::IDX_IN_FLAGS, {3'h0, m & 5'h1e});
        wr(uiq_pkg::IDX_IN_FLAGS, 8'h00);
        wr(uiq_pkg::IDX_OUT_FLAGS, 8'h00);
        irq_is(1'b0);
        sie.pair_in <= 2'h3;
        sie.pair_out <= 2'h3;
        fifo_edges(5'h1f);
        rd(uiq_pkg::IDX_IN_FLAGS, 8'h0b);
        rd(uiq_pkg::IDX_OUT_FLAGS, 8'h0b);
        sie.pair_in <= 2'h0;
        sie.pair_out <= 2'h0;
        wr(uiq_pkg::IDX_IN_FLAGS, 8'h00);
        wr(uiq_pkg::IDX_OUT_FLAGS, 8'h00);
        r = 5'($urandom_range(0, 31)) & 5'h1e;
        sie.in_ready <= r;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            sie.in_token <= 1'b1;
            sie.in_token_ep <= 3'(k);
            if (!r[k]) nq.push_back(3'(k));
            @(posedge clk);
            sie.in_token <= 1'b0;
        end
        repeat (3) @(posedge clk);
        cmp("nak_pending", 0, nq.size());
        rd(uiq_pkg::IDX_NAK_FLAGS, {3'h0, ~r});
        rd(uiq_pkg::IDX_GLB_FLAGS, 8'h10, 8'h10);
        irq_is(|(~r & q));
        wr(uiq_pkg::IDX_NAK_FLAGS, 8'h00);
        repeat (40) @(posedge clk);
        rd(uiq_pkg::IDX_GLB_FLAGS, 8'h84, 8'h84);
        cmp("sie_clk_en", 0, {31'h0, sie_clk_en});
        host_u.packet();
        repeat (4) @(posedge clk);
        rd(uiq_pkg::IDX_GLB_FLAGS, 8'h83, 8'h83);
        wr(uiq_pkg::IDX_GLB_FLAGS, 8'h00);
        repeat (2) @(posedge clk);
        cmp("sie_clk_en", 1, {31'h0, sie_clk_en});
        host_u.bus_reset(45);
        repeat (4) @(posedge clk);
        rd(uiq_pkg::IDX_GLB_FLAGS, 8'h88, 8'h88);
        rd(uiq_pkg::IDX_NAK_EN, {3'h0, q});
        wr(uiq_pkg::IDX_GLB_EN, 8'h08);
        irq_is(1'b1);
        wr(uiq_pkg::IDX_GLB_FLAGS, 8'hf7);
        irq_is(1'b0);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule : testbench
`default_nettype wire

/* testbench/uiq_host_model.sv */
// Purpose: behavioural usb host driving the bus lines
// Assumes: full speed idle is j, dp high and dm low
// Notes:   coarse bit timing, one line state per clk
`timescale 1ns/100ps
`default_nettype none
module uiq_host_model (
    input  wire logic clk,
    output logic      usb_dp,
    output logic      usb_dm
);
    initial begin
        usb_dp = 1'b1;
        usb_dm = 1'b0;
    end
    // ----------------------------------------
    // bus actions
    // ----------------------------------------
    task automatic line(input logic dp, input logic dm, input int n);
        @(posedge clk);
        usb_dp <= dp;
        usb_dm <= dm;
        repeat (n - 1) @(posedge clk);
    endtask : line
    // k/j mix, then a short se0 and back to j
    task automatic packet();
        logic [7:0] pat;
        pat = 8'h5a;
        for (int i = 0; i < 8; i++) begin
            line(pat[i], ~pat[i], 1);
        end
        line(1'b0, 1'b0, 2);
        line(1'b1, 1'b0, 1);
    endtask : packet
    // long se0; the model never leaves lines floating, so no pull level is needed
    task automatic bus_reset(input int n);
        line(1'b0, 1'b0, n);
        line(1'b1, 1'b0, 1);
    endtask : bus_reset
endmodule : uiq_host_model
`default_nettype wire
